// [etd_timebase_divider.sv]
// eeprom timebase divider: ahb-lite registers, shadow reload, lock and tick generator
`timescale 1ns/100ps
module etd_timebase_divider #(
    parameter int unsigned OP_TICKS = etd_pkg::NVM_OP_TICKS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        nvm_por_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        oscillator_output_clock,
    output logic             timebase_tick,
    output logic             nvm_busy
);

    // word offset of an address, shared by the read and write decoders
    function automatic logic [7:0] reg_offset(input logic [31:0] addr);
        reg_offset = {addr[7:2], 2'b00};
    endfunction : reg_offset

    etd_pkg::etd_state_t state_r;

    logic [10:0] divisor_r;
    logic        lock_disable_r;
    logic        ref_select_r;
    logic        latch_en_r;
    logic        refused_r;
    logic [7:0]  latch_data_r;
    logic        latch_high_r;

    etd_pkg::etd_op_t op_r;
    logic [7:0]  op_ticks_r;
    logic        erase_pulse_r;
    logic        program_pulse_r;
    logic        busy_r;

    logic        wr_pend_r;
    logic [7:0]  wr_off_r;
    logic        rd_pend_r;
    logic [7:0]  rd_off_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;

    logic        osc_meta_r;
    logic        osc_sync_r;
    logic        osc_prev_r;
    logic [10:0] count_r;
    logic        tick_r;

    logic [7:0]  shadow_high;
    logic [7:0]  shadow_low;

    logic        accept;
    logic        wr_now;
    logic        div_writable;
    logic        ref_pulse;
    logic [7:0]  wbyte;
    logic [31:0] read_mux;


    etd_shadow_store u_shadow (
        .hclk          (hclk),
        .nvm_por_n     (nvm_por_n),
        .erase_pulse   (erase_pulse_r),
        .program_pulse (program_pulse_r),
        .target_high   (latch_high_r),
        .program_data  (latch_data_r),
        .shadow_high   (shadow_high),
        .shadow_low    (shadow_low)
    );

    // ---------------- bus slave ----------------
    // only whole-word transfers are expected; narrower sizes act on the low byte
    assign accept       = hsel && htrans[1] && hready && (state_r == etd_pkg::ETD_ST_RUN);
    assign wr_now       = wr_pend_r;
    assign wbyte        = hwdata[7:0];
    assign div_writable = !latch_en_r && lock_disable_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_off_r  <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite;
            wr_off_r  <= reg_offset(haddr);
        end
    end

    // reads take one wait state so a write in the previous data phase is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r   <= 1'b0;
            rd_off_r    <= 8'h00;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
        end else if (state_r == etd_pkg::ETD_ST_LOAD) begin
            hreadyout_r <= 1'b1;
        end else if (accept && !hwrite) begin
            rd_pend_r   <= 1'b1;
            rd_off_r    <= reg_offset(haddr);
            hreadyout_r <= 1'b0;
        end else if (rd_pend_r) begin
            rd_pend_r   <= 1'b0;
            hrdata_r    <= read_mux;
            hreadyout_r <= 1'b1;
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        case (rd_off_r)
            etd_pkg::OFF_DIV_HIGH: begin
                read_mux[etd_pkg::LOCK_DISABLE_BIT]   = lock_disable_r;
                read_mux[etd_pkg::DIV_HIGH_MSB:0]     = divisor_r[10:8];
            end
            etd_pkg::OFF_DIV_LOW: begin
                read_mux[7:0] = divisor_r[7:0];
            end
            etd_pkg::OFF_SHADOW_HIGH: begin
                read_mux[7:0] = shadow_high;
            end
            etd_pkg::OFF_SHADOW_LOW: begin
                read_mux[7:0] = shadow_low;
            end
            etd_pkg::OFF_CONFIG: begin
                read_mux[etd_pkg::REF_SELECT_BIT] = ref_select_r;
            end
            etd_pkg::OFF_NVM_CTRL: begin
                read_mux[etd_pkg::LATCH_BIT]   = latch_en_r;
                read_mux[etd_pkg::ERASE_BIT]   = (op_r == etd_pkg::ETD_OP_ERASE);
                read_mux[etd_pkg::PROGRAM_BIT] = (op_r == etd_pkg::ETD_OP_PROGRAM);
            end
            etd_pkg::OFF_STATUS: begin
                read_mux[etd_pkg::BUSY_BIT]    = (op_r != etd_pkg::ETD_OP_NONE);
                read_mux[etd_pkg::REFUSED_BIT] = refused_r;
                read_mux[etd_pkg::LOADED_BIT]  = (state_r == etd_pkg::ETD_ST_RUN);
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // ---------------- reload from shadow, divisor and lock ----------------
    // the async reset only sets constants; the shadow copy is taken on the
    // first edge after release, and the bus is held off until then
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= etd_pkg::ETD_ST_LOAD;
        end else begin
            case (state_r)
                etd_pkg::ETD_ST_LOAD: state_r <= etd_pkg::ETD_ST_RUN;
                etd_pkg::ETD_ST_RUN:  state_r <= etd_pkg::ETD_ST_RUN;
                default:              state_r <= etd_pkg::ETD_ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divisor_r      <= etd_pkg::DIV_RESET;
            lock_disable_r <= etd_pkg::LOCK_DIS_RESET;
        end else if (state_r == etd_pkg::ETD_ST_LOAD) begin
            divisor_r      <= {shadow_high[etd_pkg::DIV_HIGH_MSB:0], shadow_low};
            lock_disable_r <= shadow_high[etd_pkg::LOCK_DISABLE_BIT];
        end else if (wr_now && div_writable) begin
            if (wr_off_r == etd_pkg::OFF_DIV_HIGH) begin
                divisor_r[10:8] <= wbyte[etd_pkg::DIV_HIGH_MSB:0];
                // once cleared the bit itself is locked as well
                lock_disable_r  <= wbyte[etd_pkg::LOCK_DISABLE_BIT];
            end else if (wr_off_r == etd_pkg::OFF_DIV_LOW) begin
                divisor_r[7:0] <= wbyte;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_select_r <= etd_pkg::REF_SELECT_RESET;
        end else if (wr_now && wr_off_r == etd_pkg::OFF_CONFIG) begin
            ref_select_r <= wbyte[etd_pkg::REF_SELECT_BIT];
        end
    end

    // ---------------- shadow erase and program ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_en_r <= 1'b0;
        end else if (wr_now && wr_off_r == etd_pkg::OFF_NVM_CTRL && op_r == etd_pkg::ETD_OP_NONE) begin
            latch_en_r <= wbyte[etd_pkg::LATCH_BIT];
        end
    end

    // shadow writes only capture data while the latch is open and unlocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_data_r <= etd_pkg::ERASED_BYTE;
            latch_high_r <= 1'b0;
        end else if (wr_now && latch_en_r && lock_disable_r && op_r == etd_pkg::ETD_OP_NONE) begin
            if (wr_off_r == etd_pkg::OFF_SHADOW_HIGH) begin
                latch_data_r <= wbyte;
                latch_high_r <= 1'b1;
            end else if (wr_off_r == etd_pkg::OFF_SHADOW_LOW) begin
                latch_data_r <= wbyte;
                latch_high_r <= 1'b0;
            end
        end
    end

    logic op_request;
    assign op_request = wr_now && wr_off_r == etd_pkg::OFF_NVM_CTRL && latch_en_r
                        && op_r == etd_pkg::ETD_OP_NONE
                        && (wbyte[etd_pkg::ERASE_BIT] || wbyte[etd_pkg::PROGRAM_BIT]);

    // the step lasts a fixed number of timebase ticks, so a zero divisor stalls it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_r            <= etd_pkg::ETD_OP_NONE;
            op_ticks_r      <= 8'h00;
            erase_pulse_r   <= 1'b0;
            program_pulse_r <= 1'b0;
            busy_r          <= 1'b0;
        end else begin
            erase_pulse_r   <= 1'b0;
            program_pulse_r <= 1'b0;
            if (op_request && lock_disable_r) begin
                op_r       <= wbyte[etd_pkg::ERASE_BIT] ? etd_pkg::ETD_OP_ERASE
                                                        : etd_pkg::ETD_OP_PROGRAM;
                op_ticks_r <= 8'h00;
                busy_r     <= 1'b1;
            end else if (op_r != etd_pkg::ETD_OP_NONE && tick_r) begin
                if (op_ticks_r == 8'(OP_TICKS - 1)) begin
                    erase_pulse_r   <= (op_r == etd_pkg::ETD_OP_ERASE);
                    program_pulse_r <= (op_r == etd_pkg::ETD_OP_PROGRAM);
                    op_r            <= etd_pkg::ETD_OP_NONE;
                    busy_r          <= 1'b0;
                end else begin
                    op_ticks_r <= op_ticks_r + 8'h01;
                end
            end
        end
    end

    // refusal is sticky; a new refusal in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused_r <= 1'b0;
        end else if (op_request && !lock_disable_r) begin
            refused_r <= 1'b1;
        end else if (wr_now && wr_off_r == etd_pkg::OFF_STATUS && wbyte[etd_pkg::REFUSED_BIT]) begin
            refused_r <= 1'b0;
        end
    end

    // ---------------- reference and divider ----------------
    // the oscillator is foreign to hclk; only the synced copy is edge-detected,
    // which limits it to well under half of hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= oscillator_output_clock;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    assign ref_pulse = ref_select_r ? 1'b1 : (osc_sync_r && !osc_prev_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 11'h000;
            tick_r  <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (divisor_r == 11'h000) begin
                count_r <= 11'h000;
            end else if (ref_pulse) begin
                if (count_r >= divisor_r - 11'h001) begin
                    count_r <= 11'h000;
                    tick_r  <= 1'b1;
                end else begin
                    count_r <= count_r + 11'h001;
                end
            end
        end
    end

    assign hrdata        = hrdata_r;
    assign hreadyout     = hreadyout_r;
    assign hresp         = 1'b0;
    assign timebase_tick = tick_r;
    // busy flop tracks op_r edge for edge so the pin stays glitch free
    assign nvm_busy      = busy_r;

endmodule : etd_timebase_divider

// [etd_pkg.sv]
// constants, register map and types shared by the eeprom timebase divider
package etd_pkg;

    // bus clock and the timebase the divider is meant to produce
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned TICK_PERIOD_US = 35;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_DIV_HIGH    = 8'h00;
    localparam logic [7:0] OFF_DIV_LOW     = 8'h04;
    localparam logic [7:0] OFF_SHADOW_HIGH = 8'h08;
    localparam logic [7:0] OFF_SHADOW_LOW  = 8'h0C;
    localparam logic [7:0] OFF_CONFIG      = 8'h10;
    localparam logic [7:0] OFF_NVM_CTRL    = 8'h14;
    localparam logic [7:0] OFF_STATUS      = 8'h18;

    // field positions
    localparam int unsigned LOCK_DISABLE_BIT = 7;
    localparam int unsigned DIV_HIGH_MSB     = 2;
    localparam int unsigned DIV_W            = 11;
    localparam int unsigned REF_SELECT_BIT   = 0;
    localparam int unsigned LATCH_BIT        = 0;
    localparam int unsigned ERASE_BIT        = 1;
    localparam int unsigned PROGRAM_BIT      = 2;
    localparam int unsigned BUSY_BIT         = 0;
    localparam int unsigned REFUSED_BIT      = 1;
    localparam int unsigned LOADED_BIT       = 2;

    // reset values
    localparam logic [10:0] DIV_RESET        = 11'h000;
    localparam logic        LOCK_DIS_RESET   = 1'b0;
    localparam logic        REF_SELECT_RESET = 1'b0;
    localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

    // number of timebase ticks one erase or program step lasts
    localparam int unsigned NVM_OP_TICKS = 8;

    // load the shadow copy once after reset, then run
    typedef enum logic {
        ETD_ST_LOAD = 1'b0,
        ETD_ST_RUN  = 1'b1
    } etd_state_t;

    typedef enum logic [1:0] {
        ETD_OP_NONE    = 2'b00,
        ETD_OP_ERASE   = 2'b01,
        ETD_OP_PROGRAM = 2'b10
    } etd_op_t;

endpackage : etd_pkg

// [etd_shadow_store.sv]
// nonvolatile shadow bytes holding the divisor and lock bit across system resets
`timescale 1ns/100ps
module etd_shadow_store (
    input  wire logic       hclk,
    input  wire logic       nvm_por_n,
    input  wire logic       erase_pulse,
    input  wire logic       program_pulse,
    input  wire logic       target_high,
    input  wire logic [7:0] program_data,
    output logic      [7:0] shadow_high,
    output logic      [7:0] shadow_low
);

    logic [7:0] cell_r [2];

    // index 0 is the low shadow, index 1 the high shadow
    for (genvar g = 0; g < 2; g++) begin : g_cell
        logic hit;
        assign hit = (target_high == 1'(g));
        // every nvm_por_n assertion loads the erased byte; system reset does not touch it
        always_ff @(posedge hclk or negedge nvm_por_n) begin
            if (!nvm_por_n) begin
                cell_r[g] <= etd_pkg::ERASED_BYTE;
            end else if (erase_pulse && hit) begin
                cell_r[g] <= etd_pkg::ERASED_BYTE;
            end else if (program_pulse && hit) begin
                // programming can only pull bits from 1 to 0
                cell_r[g] <= cell_r[g] & program_data;
            end
        end
    end

    assign shadow_low  = cell_r[0];
    assign shadow_high = cell_r[1];

endmodule : etd_shadow_store

// [etd_timebase_divider_checker.sv]
// bus timing and output relations of the timebase divider, bound to its ports
`timescale 1ns/100ps
module etd_timebase_divider_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        timebase_tick,
    input wire logic        nvm_busy
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire take    = hsel && htrans[1] && hready && hreadyout;
    wire rd_take = take && !hwrite;
    wire wr_take = take && hwrite;

    a_resp_okay: assert property (hresp == 1'b0) else $error("bus response is not okay");
    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read did not insert exactly one wait");
    a_write_nowait: assert property (wr_take |=> hreadyout) else $error("write stalled");
    a_ready_after_reset: assert property ($rose(hresetn) |=> hreadyout)
        else $error("bus not ready after reset load");
    a_single_wait: assert property (!hreadyout |=> hreadyout) else $error("wait longer than one cycle");
    a_ready_hold: assert property (hreadyout && !rd_take |=> hreadyout) else $error("spurious wait state");
    a_rdata_stable: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd_take && haddr[7:0] >= 8'h1C |=> ##1 hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper read bits not zero");
    a_busy_end_tick: assert property ($fell(nvm_busy) |->
        ($past(timebase_tick, 1) || $past(timebase_tick, 2) || $past(timebase_tick, 3)))
        else $error("operation ended without a timebase tick");
endmodule : etd_timebase_divider_checker

bind etd_timebase_divider etd_timebase_divider_checker i_etd_timebase_divider_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timebase_tick(timebase_tick), .nvm_busy(nvm_busy));

// [etd_timebase_divider_tb.sv]
// self-checking testbench of the timebase divider over its ahb-lite port
`timescale 1ns/100ps
module etd_timebase_divider_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        nvm_por_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        osc = 1'b0;
    logic        timebase_tick;
    logic        nvm_busy;
    logic [7:0]  rd_q;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    // {write, offset, data or expected read}
    logic [16:0] rows [0:13] = '{17'h008FF, 17'h00CFF, 17'h00087, 17'h004FF, 17'h01000, 17'h01804,
        17'h01C00, 17'h10405, 17'h10080, 17'h00080, 17'h00405, 17'h11001, 17'h01001, 17'h11C55};

    always #5 hclk = ~hclk;
    initial begin
        #3;
        forever #50 osc = ~osc;
    end

    etd_timebase_divider #(.OP_TICKS(2)) i_etd_timebase_divider (
        .hclk(hclk), .hresetn(hresetn), .nvm_por_n(nvm_por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .oscillator_output_clock(osc),
        .timebase_tick(timebase_tick), .nvm_busy(nvm_busy));

    task check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // ready and read data are taken at the rising edge, before that edge's own updates land
    task wait_ready;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
        rd_q = hrdata[7:0];
    endtask : wait_ready

    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_ready();
    endtask : bus

    task rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd_q, exp);
    endtask : rd

    task count_ticks(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge hclk);
            #1;
            if (timebase_tick === 1'b1) n++;
        end
        @(posedge hclk);
    endtask : count_ticks

    task run_op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        int k;
        k = 0;
        bus(1'b1, a, d);
        bus(1'b1, 8'h14, c);
        @(posedge hclk);
        check({7'h00, nvm_busy}, 8'h01);
        rd(8'h14, c);
        while (nvm_busy !== 1'b0 && k < 400) begin
            @(posedge hclk);
            k++;
        end
        check({7'h00, nvm_busy}, 8'h00);
    endtask : run_op

    task pulse_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : pulse_reset

    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn   <= 1'b1;
        nvm_por_n <= 1'b1;
        repeat (2) @(posedge hclk);
        // blank shadows load divisor 0x7FF with lock off; table rows then poke the map
        for (int i = 0; i < 14; i++) begin
            if (rows[i][16]) bus(1'b1, rows[i][15:8], rows[i][7:0]);
            else rd(rows[i][15:8], rows[i][7:0]);
        end
        rd(8'h1C, 8'h00);
        $display("test register map done");
        count_ticks(100);
        check(n[7:0], 8'd20);
        bus(1'b1, 8'h10, 8'h00);
        bus(1'b1, 8'h04, 8'h05);
        count_ticks(1000);
        check((n >= 19 && n <= 21) ? 8'h01 : 8'h00, 8'h01);
        // 10 MHz oscillator: int(10e6 * 35e-6 + 0.5) = 350 = 0x15E, one tick per 3500 bus cycles
        bus(1'b1, 8'h00, 8'h81);
        bus(1'b1, 8'h04, 8'h5E);
        count_ticks(7500);
        check(n[7:0], 8'd2);
        bus(1'b1, 8'h10, 8'h01);
        bus(1'b1, 8'h00, 8'h80);
        bus(1'b1, 8'h04, 8'h05);
        $display("test tick rate done");
        bus(1'b1, 8'h14, 8'h01);
        bus(1'b1, 8'h04, 8'h33);
        rd(8'h04, 8'h05);
        run_op(8'h0C, 8'h03, 8'h05);
        rd(8'h0C, 8'h03);
        run_op(8'h0C, 8'h00, 8'h03);
        rd(8'h0C, 8'hFF);
        run_op(8'h0C, 8'h03, 8'h05);
        rd(8'h0C, 8'h03);
        run_op(8'h08, 8'h02, 8'h05);
        rd(8'h08, 8'h02);
        rd(8'h04, 8'h05);
        $display("test shadow program done");
        pulse_reset();
        rd(8'h00, 8'h02);
        rd(8'h04, 8'h03);
        rd(8'h0C, 8'h03);
        bus(1'b1, 8'h14, 8'h00);
        bus(1'b1, 8'h00, 8'h87);
        bus(1'b1, 8'h04, 8'hAA);
        rd(8'h00, 8'h02);
        rd(8'h04, 8'h03);
        bus(1'b1, 8'h14, 8'h01);
        bus(1'b1, 8'h14, 8'h03);
        @(posedge hclk);
        check({7'h00, nvm_busy}, 8'h00);
        rd(8'h18, 8'h06);
        bus(1'b1, 8'h18, 8'h02);
        rd(8'h18, 8'h04);
        rd(8'h08, 8'h02);
        pulse_reset();
        rd(8'h00, 8'h02);
        $display("test lock done");
        finish_test();
    end
endmodule : etd_timebase_divider_tb
